// >>> sac_ctrl.sv
// Serial control and result output of a 12-bit plus sign converter
`timescale 1ns/1ps
`default_nettype none
module sac_ctrl #(
  parameter int PROGRAM_ENABLE_N_CYCLES = sac_pkg::PROGRAM_ENABLE_N_CYCLES,
  parameter int CAL_CYCLES = sac_pkg::CAL_CYCLES,
  parameter int AZ_CYCLES = sac_pkg::AZ_CYCLES
) (
  // System clock, reset, enable
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic ce,
  // Serial link pins
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic serial_in,
  input wire logic program_enable_n,
  output logic serial_out,
  output logic serial_out_oe_n,
  // Status pins
  output logic eoc,
  output logic output_ready,
  // Converter core side
  output logic [2:0] mux_sel,
  output logic mux_diff,
  input wire logic [11:0] sample_pos,
  input wire logic [11:0] sample_neg
);

  ////////////////////////////////////////////////////////////////////
  // Declarations

  // Link side
  logic frame_clr;
  logic [4:0] in_cnt;
  logic [4:0] out_idx;
  logic [7:0] in_shift;
  logic [7:0] cmd;
  logic prog_flag;
  logic done_tgl;
  logic out_bit;
  logic [7:0] next_cmd;

  // System side
  logic [2:0] sync_q;
  logic cs_s;
  logic done_s;
  logic pe_s;
  logic cs_prev;
  logic done_prev;
  logic cs_fall;
  logic done_evt;
  sac_pkg::sac_state_t state;
  logic [11:0] timer;
  logic [4:0] word_len;
  logic [16:0] out_word;
  logic [3:0] op;

  ////////////////////////////////////////////////////////////////////
  // Functions

  // Pick one bit of the left-aligned output word
  function automatic logic word_bit(
    input logic [16:0] w,
    input logic [4:0] n
  );
    logic [4:0] pos;
    pos = 5'(sac_pkg::WORD_W - 1) - n;
    return w[pos];
  endfunction

  // Next position of a counter that wraps at the word length
  function automatic logic [4:0] wrap_inc(
    input logic [4:0] c,
    input logic [4:0] len
  );
    logic [4:0] nxt;
    nxt = c + 5'h01;
    if (nxt >= len) begin
      nxt = 5'h00;
    end
    return nxt;
  endfunction

  // Sign and magnitude of pos minus neg
  function automatic logic [12:0] sign_mag(
    input logic [11:0] p,
    input logic [11:0] n
  );
    logic [12:0] diff;
    logic [12:0] mag;
    diff = {1'b0, p} - {1'b0, n};
    mag = diff[12] ? (13'h0000 - diff) : diff;
    return {diff[12], mag[11:0]};
  endfunction

  ////////////////////////////////////////////////////////////////////
  // Link domain, clocked by sclk
  // These flops ignore ce: the host owns this clock, and freezing them
  // here would lose count of the bits that the host is still sending

  // Counters restart whenever select goes high
  assign frame_clr = cs_n | ~resetn;

  // Command bits as they stand after this rising edge
  assign next_cmd = {in_shift[6:0], serial_in};

  // Rising edges counted against the expected word length
  always_ff @(posedge sclk or posedge frame_clr) begin
    if (frame_clr) begin
      in_cnt <= 5'h00;
    end else begin
      in_cnt <= wrap_inc(in_cnt, word_len);
    end
  end

  // Input shifter; frozen in read-only transfers
  always_ff @(posedge sclk or negedge resetn) begin
    if (!resetn) begin
      in_shift <= 8'h00;
    end else if (!cs_n && !program_enable_n) begin
      in_shift <= next_cmd;
    end
  end

  // Word end: hand command and frame event to sys_clk
  always_ff @(posedge sclk or negedge resetn) begin
    if (!resetn) begin
      cmd <= 8'h00;
      prog_flag <= 1'b0;
      done_tgl <= 1'b0;
    end else if (!cs_n && in_cnt == word_len - 5'h01) begin
      done_tgl <= ~done_tgl;
      // Read-only words are counted but never committed
      prog_flag <= ~program_enable_n;
      if (!program_enable_n) begin
        cmd <= next_cmd;
      end
    end
  end

  // Falling edges step through the result word
  always_ff @(negedge sclk or posedge frame_clr) begin
    if (frame_clr) begin
      out_idx <= 5'h00;
      out_bit <= 1'b0;
    end else begin
      out_idx <= wrap_inc(out_idx, word_len);
      out_bit <= word_bit(out_word,
                          wrap_inc(out_idx, word_len));
    end
  end

  // word_len and out_word are read here without synchronising; they
  // change only between words, so a result must not land mid-word
  // First bit straight from the word so it shows at select fall
  // or at busy rise; later bits come from the falling-edge flop
  assign serial_out = (out_idx == 5'h00) ?
                      out_word[sac_pkg::WORD_W - 1] : out_bit;
  assign serial_out_oe_n = cs_n;

  ////////////////////////////////////////////////////////////////////
  // Crossing into sys_clk

  // Select, frame toggle and program enable, each a level. Select
  // and program enable go in inverted, so the synchroniser's zero
  // reset reads as an idle link and no false select fall follows reset
  sac_sync #(
    .W(3)
  ) u_sync (
    .clk(sys_clk),
    .resetn(resetn),
    .ce(ce),
    .d({~cs_n, done_tgl, ~program_enable_n}),
    .q(sync_q)
  );

  assign cs_s = ~sync_q[2];
  assign done_s = sync_q[1];
  assign pe_s = ~sync_q[0];

  // Edge history of the synchronised levels
  // Reset to the idle levels so the first edges after reset are real
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      cs_prev <= 1'b1;
      done_prev <= 1'b0;
    end else if (ce) begin
      cs_prev <= cs_s;
      done_prev <= done_s;
    end
  end

  assign cs_fall = cs_prev & ~cs_s;
  assign done_evt = done_prev ^ done_s;

  // cmd and prog_flag are read without synchronising: both settle at
  // the word's last rising edge, cycles before done_evt can fire
  assign op = cmd[sac_pkg::OP_LSB +: sac_pkg::OP_W];

  ////////////////////////////////////////////////////////////////////
  // Converter sequencer

  // Starts, aborts and ends conversion, calibration, zero, sleep
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      state <= sac_pkg::SAC_IDLE;
      timer <= 12'h000;
    end else if (ce) begin
      if (cs_fall && !pe_s) begin
        // Abort; the word now shifting out may be corrupt
        state <= sac_pkg::SAC_WAIT;
        timer <= 12'h000;
      end else if (done_evt && prog_flag) begin
        unique case (op)
          sac_pkg::OP_CALIBRATE: begin
            state <= sac_pkg::SAC_CAL;
            timer <= 12'(CAL_CYCLES - 1);
          end
          sac_pkg::OP_AUTO_ZERO: begin
            state <= sac_pkg::SAC_ZERO;
            timer <= 12'(AZ_CYCLES - 1);
          end
          sac_pkg::OP_POWER_DOWN: begin
            state <= sac_pkg::SAC_PDN;
            timer <= 12'h000;
          end
          default: begin
            state <= sac_pkg::SAC_PROGRAM_ENABLE_N;
            timer <= 12'(PROGRAM_ENABLE_N_CYCLES - 1);
          end
        endcase
      end else begin
        unique case (state)
          sac_pkg::SAC_PROGRAM_ENABLE_N,
          sac_pkg::SAC_CAL,
          sac_pkg::SAC_ZERO: begin
            if (timer == 12'h000) begin
              state <= sac_pkg::SAC_IDLE;
            end else begin
              timer <= timer - 12'h001;
            end
          end
          default: begin
            // Idle, aborted or asleep until the next command
            state <= state;
          end
        endcase
      end
    end
  end

  // Busy low in every state but idle
  assign eoc = (state == sac_pkg::SAC_IDLE);

  ////////////////////////////////////////////////////////////////////
  // Configuration

  // Only a programming word changes channel, mode or length
  // A read-only word leaves all of this alone, as does an abort
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      mux_sel <= sac_pkg::CHAN_RST;
      mux_diff <= 1'b0;
      word_len <= sac_pkg::LEN_SHORT;
    end else if (ce && done_evt && prog_flag) begin
      mux_sel <= cmd[sac_pkg::CHAN_LSB +: sac_pkg::CHAN_W];
      mux_diff <= cmd[sac_pkg::DIFF_BIT];
      if (op == sac_pkg::OP_PROGRAM_ENABLE_N_SHORT) begin
        word_len <= sac_pkg::LEN_SHORT;
      end else if (op == sac_pkg::OP_PROGRAM_ENABLE_N_LONG) begin
        word_len <= sac_pkg::LEN_LONG;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Result word

  // Loaded at conversion end, left-aligned so the first bit
  // always sits in the top position
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      out_word <= sac_pkg::WORD_RST;
    end else if (ce && state == sac_pkg::SAC_PROGRAM_ENABLE_N &&
                 timer == 12'h000 && !(cs_fall && !pe_s) &&
                 !(done_evt && prog_flag)) begin
      if (word_len == sac_pkg::LEN_LONG) begin
        // Status prefix: input mode and channel
        out_word <= {mux_diff, mux_sel,
                     sign_mag(sample_pos,
                              mux_diff ? sample_neg
                                       : 12'h000)};
      end else begin
        out_word <= {sign_mag(sample_pos,
                              mux_diff ? sample_neg
                                       : 12'h000),
                     4'h0};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Output ready

  // A fresh result pulls ready low; a finished word raises it.
  // A result finishing in the same cycle as a read-only word wins; a programming word ending then drops it
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      output_ready <= 1'b1;
    end else if (ce) begin
      if (state == sac_pkg::SAC_PROGRAM_ENABLE_N && timer == 12'h000 &&
          !(cs_fall && !pe_s) && !(done_evt && prog_flag)) begin
        output_ready <= 1'b0;
      end else if (done_evt) begin
        output_ready <= 1'b1;
      end
    end
  end

endmodule
`default_nettype wire

// >>> sac_pkg.sv
// Shared constants for the serial converter control block
package sac_pkg;
  // Command word shifted in on the serial input
  localparam int CMD_W = 8;
  localparam int CHAN_LSB = 0;
  localparam int CHAN_W = 3;
  localparam int DIFF_BIT = 3;
  localparam int OP_LSB = 4;
  localparam int OP_W = 4;

  // Operation codes in the command word
  localparam logic [3:0] OP_PROGRAM_ENABLE_N_SHORT = 4'h0;
  localparam logic [3:0] OP_PROGRAM_ENABLE_N_LONG = 4'h1;
  localparam logic [3:0] OP_CALIBRATE = 4'h2;
  localparam logic [3:0] OP_AUTO_ZERO = 4'h3;
  localparam logic [3:0] OP_POWER_DOWN = 4'h4;

  // Output word: sign plus 12-bit magnitude, optional status prefix
  localparam int MAG_W = 12;
  localparam int RES_W = 13;
  localparam int STAT_W = 4;
  localparam int WORD_W = 17;
  localparam int LEN_W = 5;
  localparam logic [4:0] LEN_SHORT = 5'h0D;
  localparam logic [4:0] LEN_LONG = 5'h11;

  // Reset values
  localparam logic [2:0] CHAN_RST = 3'h0;
  localparam logic [16:0] WORD_RST = 17'h00000;

  // Cycle counts of the converter sequences, in sys_clk cycles
  localparam int PROGRAM_ENABLE_N_CYCLES = 44;
  localparam int CAL_CYCLES = 400;
  localparam int AZ_CYCLES = 40;
  localparam int TMR_W = 12;

  // Converter sequencer states
  typedef enum logic [5:0] {
    SAC_IDLE = 6'h01,
    SAC_WAIT = 6'h02,
    SAC_PROGRAM_ENABLE_N = 6'h04,
    SAC_CAL = 6'h08,
    SAC_ZERO = 6'h10,
    SAC_PDN = 6'h20
  } sac_state_t;
endpackage

// >>> sac_sync.sv
// Two-flop level synchroniser for signals entering sys_clk
`timescale 1ns/1ps
`default_nettype none
module sac_sync #(
  parameter int W = 1
) (
  // Clock, reset, enable
  input wire logic clk,
  input wire logic resetn,
  input wire logic ce,
  // Levels in and out
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] stage1;

  // First stage feeds only the second stage
  always_ff @(posedge clk) begin
    if (!resetn) begin
      stage1 <= '0;
      q <= '0;
    end else if (ce) begin
      stage1 <= d;
      q <= stage1;
    end
  end
endmodule
`default_nettype wire

// >>> sac_ctrl_props.sv
// Concurrent checks on the pins of the converter control block
`timescale 1ns/1ps
`default_nettype none
module sac_ctrl_props #(
  parameter int PROGRAM_ENABLE_N_CYCLES = sac_pkg::PROGRAM_ENABLE_N_CYCLES,
  parameter int CAL_CYCLES = sac_pkg::CAL_CYCLES,
  parameter int AZ_CYCLES = sac_pkg::AZ_CYCLES
) (
  // Clocks and reset
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic sclk,
  // Link pins
  input wire logic cs_n,
  input wire logic program_enable_n,
  input wire logic serial_out,
  input wire logic serial_out_oe_n,
  // Status and channel
  input wire logic eoc,
  input wire logic output_ready,
  input wire logic [2:0] mux_sel,
  input wire logic mux_diff
);
  localparam int MIN_A = (PROGRAM_ENABLE_N_CYCLES < AZ_CYCLES) ? PROGRAM_ENABLE_N_CYCLES : AZ_CYCLES;
  localparam int MIN_LOW = (MIN_A < CAL_CYCLES) ? MIN_A : CAL_CYCLES;
  int low_cnt;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  ////////////////////////////////////////////////////////////////////////////
  // Length of the current busy stretch, read when busy ends
  always_ff @(posedge sys_clk) begin
    low_cnt <= (!resetn || eoc) ? 0 : low_cnt + 1;
  end
  ////////////////////////////////////////////////////////////////////////////
  a_oe_tracks_cs: assert property (serial_out_oe_n == cs_n)
    else $error("output enable differs from select");
  a_busy_min_len: assert property ($rose(eoc) |-> low_cnt >= MIN_LOW)
    else $error("busy stretch too short");
  a_rdy_falls_done: assert property ($fell(output_ready) |-> $rose(eoc))
    else $error("output ready fell without a cycle end");
  a_chan_when_busy: assert property (($changed(mux_sel) ||
    $changed(mux_diff)) |-> !eoc)
    else $error("channel changed while idle");
  // Word reload and select changes may move the pin too, so those are allowed
  a_out_moves_edge: assert property ($changed(serial_out) |-> $fell(sclk) ||
    $rose(sclk) || $changed(cs_n) || $rose(eoc))
    else $error("serial output moved off a clock edge");
  a_rdy_holds_idle: assert property ((!output_ready && cs_n &&
    $past(cs_n, 8)) |=> !output_ready)
    else $error("output ready rose with no transfer");
  a_idle_no_start: assert property ((eoc && cs_n && $past(cs_n, 8))
    |=> eoc)
    else $error("busy began with no transfer");
  a_reset_values: assert property ($rose(resetn) |-> eoc && output_ready &&
    mux_sel == 3'h0 && !mux_diff)
    else $error("wrong state after reset");
  c_cycle_end: cover property ($rose(eoc));
  c_result_ready: cover property ($fell(output_ready));
  c_read_only: cover property ($fell(cs_n) && program_enable_n);
  c_abort_busy: cover property ($fell(cs_n) && !program_enable_n && !eoc);
endmodule
`default_nettype wire

// >>> sac_host.sv
// Host side of the serial link: frames of clock pulses, both directions
`timescale 1ns/1ps
`default_nettype none
module sac_host (
  // Pins driven by the host
  output logic sclk,
  output logic cs_n,
  output logic serial_in,
  output logic program_enable_n,
  // Pins driven by the converter
  input wire logic serial_out,
  input wire logic serial_out_oe_n
);
  // Idle link: clock parked low, select high
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    serial_in = 1'b0;
    program_enable_n = 1'b1;
  end
  // One frame, MSB first; odd offset keeps sclk off sys_clk edges
  task automatic xfer(input logic [16:0] word, input int len,
      input logic pe_n, output logic [16:0] rx);
    rx = 17'h00000;
    #1.3 program_enable_n = pe_n;
    #80 cs_n = 1'b0; // Select falls while clock is low
    for (int i = len - 1; i >= 0; i--) begin
      serial_in = word[i];
      // An undriven line reads inverted, so a missing enable shows up
      #80 rx = {rx[15:0], serial_out_oe_n ? ~serial_out : serial_out};
      sclk = 1'b1;
      #80 sclk = 1'b0;
    end
    #80 cs_n = 1'b1;
    serial_in = ~serial_in; // Released line never shows the stale bit
  endtask
endmodule
`default_nettype wire

// >>> sac_ctrl_bench.sv
// Self-checking bench for the converter control block
`timescale 1ns/1ps
`default_nettype none
module sac_ctrl_bench;
  logic sys_clk, resetn, ce;
  logic [11:0] sample_pos, sample_neg;
  wire logic sclk, cs_n, serial_in, program_enable_n, serial_out;
  wire logic serial_out_oe_n, eoc, output_ready, mux_diff;
  wire logic [2:0] mux_sel;
  int error_cnt = 0;
  int comparisons = 0;
  int cycles = 0;
  ////////////////////////////////////////////////////////////////////////////
  // Calibration count cut for a brief run; conversion and zero counts raised so a cycle
  // is still running when the command word's frame has ended
  sac_ctrl #(.PROGRAM_ENABLE_N_CYCLES(96), .CAL_CYCLES(192), .AZ_CYCLES(96)) dut_u (
    .sys_clk(sys_clk), .resetn(resetn), .ce(ce), .sclk(sclk), .cs_n(cs_n),
    .serial_in(serial_in), .program_enable_n(program_enable_n),
    .serial_out(serial_out), .serial_out_oe_n(serial_out_oe_n), .eoc(eoc),
    .output_ready(output_ready), .mux_sel(mux_sel), .mux_diff(mux_diff),
    .sample_pos(sample_pos), .sample_neg(sample_neg));
  sac_host host_u (.sclk(sclk), .cs_n(cs_n), .serial_in(serial_in),
    .program_enable_n(program_enable_n), .serial_out(serial_out),
    .serial_out_oe_n(serial_out_oe_n));
  ////////////////////////////////////////////////////////////////////////////
  // Clock and hang guard
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      error_cnt++;
      wrap_up();
    end
  end
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic check(input logic [16:0] got, input logic [16:0] exp);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t got %0h expected %0h", $time, got, exp);
    end
  endtask
  // Bounded wait for the busy pin to reach a level
  task automatic wait_eoc(input logic lvl);
    for (int k = 0; k < 2000 && eoc !== lvl; k++) @(negedge sys_clk);
    check({16'h0000, eoc}, {16'h0000, lvl});
  endtask
  // Sign and magnitude of the sample difference, long form adds status
  function automatic logic [16:0] exp_word(input logic [11:0] p, n,
      input logic d, input logic [2:0] ch, input logic lng);
    logic [11:0] nn;
    logic [12:0] r;
    nn = d ? n : 12'h000;
    r = (p >= nn) ? {1'b0, p - nn} : {1'b1, nn - p};
    return lng ? {d, ch, r} : {4'h0, r};
  endfunction
  ////////////////////////////////////////////////////////////////////////////
  // Every operation once, then random conversions in both formats
  initial begin
    logic [3:0] op;
    logic [2:0] ch;
    logic d;
    logic [11:0] p, n;
    logic [16:0] rx;
    int wlen;
    ce = 1'b1;
    resetn = 1'b0;
    sample_pos = 12'h000;
    sample_neg = 12'h000;
    wlen = 13;
    void'($urandom(85));
    repeat (16) @(posedge sys_clk);
    resetn <= 1'b1;
    repeat (4) @(posedge sys_clk);
    for (int t = 0; t < 12; t++) begin
      op = (t < 5) ? t[3:0] : {3'h0, 1'($urandom)};
      ch = 3'($urandom);
      d = (t == 6) | 1'($urandom);
      p = (t == 6) ? 12'h000 : 12'($urandom);
      n = (t == 6) ? 12'hFFF : 12'($urandom);
      @(posedge sys_clk);
      sample_pos <= p;
      sample_neg <= n;
      host_u.xfer({9'h000, op, d, ch}, wlen, 1'b0, rx);
      if (t == 7) begin
        // Second word while converting: aborts and restarts
        check({16'h0000, eoc}, 17'h00000);
        host_u.xfer({9'h000, op, d, ch}, op[0] ? 17 : 13, 1'b0, rx);
      end
      if (op == 4'h4) begin
        repeat (300) @(negedge sys_clk);
        check({16'h0000, eoc}, 17'h00000);
        continue;
      end
      wait_eoc(1'b0);
      if (t == 5) begin
        // A low clock enable freezes the busy timer
        @(posedge sys_clk) ce <= 1'b0;
        repeat (120) @(posedge sys_clk);
        ce <= 1'b1;
        @(negedge sys_clk);
        check({16'h0000, eoc}, 17'h00000);
      end
      wait_eoc(1'b1);
      check({13'h0000, mux_diff, mux_sel}, {13'h0000, d, ch});
      if (op > 4'h1) continue;
      wlen = op[0] ? 17 : 13;
      check({16'h0000, output_ready}, 17'h00000);
      @(posedge sys_clk);
      sample_pos <= 12'($urandom);
      host_u.xfer(17'h1FFFF, wlen, 1'b1, rx);
      check(rx, exp_word(p, n, d, ch, op[0]));
      repeat (50) @(negedge sys_clk);
      check({12'h000, eoc, output_ready, mux_sel}, {14'h3, ch});
    end
    wrap_up();
  end
endmodule
bind sac_ctrl sac_ctrl_props #(.PROGRAM_ENABLE_N_CYCLES(PROGRAM_ENABLE_N_CYCLES),
  .CAL_CYCLES(CAL_CYCLES), .AZ_CYCLES(AZ_CYCLES)) props_u (
  .sys_clk(sys_clk), .resetn(resetn), .sclk(sclk), .cs_n(cs_n),
  .program_enable_n(program_enable_n), .serial_out(serial_out),
  .serial_out_oe_n(serial_out_oe_n), .eoc(eoc),
  .output_ready(output_ready), .mux_sel(mux_sel), .mux_diff(mux_diff));
`default_nettype wire
